/* rtl/usr_rx_top.sv */
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`default_nettype none

// What this block does
// - Sample line only with unit and receive enabled.
// - Level zero: falling edge starts, low confirms.
// - Level one: rising edge starts, high confirms.
// - Shift bits; stop moves buffer, pulses complete.
// - Overrun frame never overwrites the buffer.
// - Parity/framing errors signalled after stop bit.
// - Unread buffer at next frame gives overrun.
// - Only first stop bit is checked.
// - Each error sets flag and error request.
// - Writing one to clear trigger clears flag.
// - Parity mismatch sets parity error flag.
// - Missing stop level sets framing error flag.
// - Frame before buffer read sets overrun flag.
// - Routing bit picks separate or merged error interrupt.
// - Filter accepts level after two equal samples.
// - Separate transmit and receive baud counters.
// - Internal logic idles while unit disabled.
// - Transmit counter held zero unless both enabled.
// - Transmit counter clears on buffer write.
// - Receive counter runs only during a frame.
// - Bit time is twice the divisor.
module usr_rx_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite write address and data
  input wire logic [usr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [usr_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [usr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [usr_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial line and interrupts
  input wire logic serial_rx_pin,
  output logic rx_complete_irq,
  output logic rx_error_irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] mode_control_reg_a_q;
  logic [7:0] mode_control_reg_b_q;
  logic [7:0] baud_divisor_reg_q;
  logic [7:0] rx_buffer_reg_q;
  logic [usr_pkg::ERR_FLAGS-1:0] err_flags_q;
  logic buf_full_q;
  logic status_read_armed_q;

  logic aw_held_q;
  logic [usr_pkg::ADDR_W-1:0] aw_addr_q;
  logic w_held_q;
  logic [7:0] w_data_q;
  logic w_strb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [usr_pkg::DATA_W-1:0] rdata_q;

  logic sync1_q;
  logic sync2_q;
  logic samp_q;
  logic filt_q;
  logic prev_norm_q;
  usr_pkg::usr_rx_state_e state_q;
  logic phase_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic par_acc_q;
  logic par_err_q;
  logic rx_complete_irq_q;
  logic rx_error_irq_q;

  logic unit_enable;
  logic rx_active;
  logic err_route;
  logic line_level;
  logic [1:0] parity_mode;
  logic parity_on;
  logic [3:0] data_bits;
  logic norm;
  logic start_edge;
  logic rx_tick;
  logic tx_tick;
  logic [7:0] tx_count;
  logic [7:0] rx_count;
  logic sample;
  logic done;
  logic [usr_pkg::ERR_FLAGS-1:0] err_set;
  logic [usr_pkg::ERR_FLAGS-1:0] err_clr;
  logic do_write;
  logic ar_hs;
  logic rd_status;
  logic rd_rx_buf;
  logic wr_clear;
  logic wr_tx_buf;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic [usr_pkg::ADDR_W-1:0] word_addr(input logic [usr_pkg::ADDR_W-1:0] a);
    word_addr = {a[usr_pkg::ADDR_W-1:2], 2'h0};
  endfunction

  function automatic logic is_mapped(input logic [usr_pkg::ADDR_W-1:0] a);
    logic [usr_pkg::ADDR_W-1:0] w;
    w = word_addr(a);
    is_mapped = (w == usr_pkg::OFF_MODE_A) || (w == usr_pkg::OFF_MODE_B) || (w == usr_pkg::OFF_DIVISOR) ||
                (w == usr_pkg::OFF_RX_BUF) || (w == usr_pkg::OFF_TX_BUF) || (w == usr_pkg::OFF_STATUS) ||
                (w == usr_pkg::OFF_CLEAR) || (w == usr_pkg::OFF_COUNTERS);
  endfunction

  // ****************************************************************
  // Configuration fields
  // ****************************************************************
  // unit enable gates the receive sequencer and both baud counters
  assign unit_enable = mode_control_reg_a_q[usr_pkg::MA_ENABLE_BIT];
  assign rx_active = unit_enable & mode_control_reg_a_q[usr_pkg::MA_RX_ENABLE_BIT];
  assign err_route = mode_control_reg_a_q[usr_pkg::MA_ERR_ROUTE_BIT];
  assign line_level = mode_control_reg_b_q[usr_pkg::MB_LEVEL_BIT];
  assign parity_mode = mode_control_reg_b_q[usr_pkg::MB_PARITY_LSB +: 2];
  assign parity_on = (parity_mode == usr_pkg::PAR_EVEN) || (parity_mode == usr_pkg::PAR_ODD);
  assign data_bits = mode_control_reg_b_q[usr_pkg::MB_LEN7_BIT] ? usr_pkg::DATA_BITS_7 : usr_pkg::DATA_BITS_8;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  // Address and data are taken in either order; the write lands when both are held.
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  assign do_write = aw_held_q & w_held_q;
  assign ar_hs = s_axi_arvalid & ~rvalid_q;
  assign rd_status = ar_hs & (word_addr(s_axi_araddr) == usr_pkg::OFF_STATUS);
  assign rd_rx_buf = ar_hs & (word_addr(s_axi_araddr) == usr_pkg::OFF_RX_BUF);
  assign wr_clear = do_write & w_strb0_q & (word_addr(aw_addr_q) == usr_pkg::OFF_CLEAR);
  assign wr_tx_buf = do_write & w_strb0_q & (word_addr(aw_addr_q) == usr_pkg::OFF_TX_BUF);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q <= 1'b0;
      w_data_q <= 8'h00;
      w_strb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= usr_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_strb0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(aw_addr_q) ? usr_pkg::RESP_OKAY : usr_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_control_reg_a_q <= usr_pkg::MODE_A_RESET;
      mode_control_reg_b_q <= usr_pkg::MODE_B_RESET;
      baud_divisor_reg_q <= usr_pkg::DIVISOR_RESET;
    end else if (do_write && w_strb0_q) begin
      case (word_addr(aw_addr_q))
        usr_pkg::OFF_MODE_A: mode_control_reg_a_q <= w_data_q;
        usr_pkg::OFF_MODE_B: mode_control_reg_b_q <= w_data_q;
        usr_pkg::OFF_DIVISOR: baud_divisor_reg_q <= w_data_q;
        default: ;
      endcase
    end
  end

  // Reads are answered one cycle after the address is taken.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
      rresp_q <= usr_pkg::RESP_OKAY;
      rdata_q <= '0;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rresp_q <= is_mapped(s_axi_araddr) ? usr_pkg::RESP_OKAY : usr_pkg::RESP_SLVERR;
      case (word_addr(s_axi_araddr))
        usr_pkg::OFF_MODE_A: rdata_q <= {24'h000000, mode_control_reg_a_q};
        usr_pkg::OFF_MODE_B: rdata_q <= {24'h000000, mode_control_reg_b_q};
        usr_pkg::OFF_DIVISOR: rdata_q <= {24'h000000, baud_divisor_reg_q};
        usr_pkg::OFF_RX_BUF: rdata_q <= {24'h000000, rx_buffer_reg_q};
        usr_pkg::OFF_STATUS: rdata_q <= {27'h0000000, state_q != usr_pkg::RX_IDLE, buf_full_q, err_flags_q};
        usr_pkg::OFF_COUNTERS: rdata_q <= {16'h0000, rx_count, tx_count};
        default: rdata_q <= '0;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Line synchroniser and noise filter
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= serial_rx_pin;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      samp_q <= 1'b1;
      filt_q <= 1'b1;
    end else begin
      samp_q <= sync2_q;
      if (sync2_q == samp_q) begin
        filt_q <= sync2_q;
      end
    end
  end

  // The line is normalised so that idle is high and a start bit is low in either level mode.
  // filtered line only
  assign norm = filt_q ^ line_level;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_norm_q <= 1'b1;
    end else begin
      prev_norm_q <= norm;
    end
  end

  assign start_edge = prev_norm_q & ~norm;

  // ****************************************************************
  // Baud counters
  // ****************************************************************
  usr_baud_gen u_baud (
    .clk(clk),
    .reset_n(reset_n),
    .unit_enable(unit_enable),
    .tx_enable(mode_control_reg_a_q[usr_pkg::MA_TX_ENABLE_BIT]),
    .rx_enable(mode_control_reg_a_q[usr_pkg::MA_RX_ENABLE_BIT]),
    .divisor(baud_divisor_reg_q),
    .tx_clear(wr_tx_buf),
    .rx_run(state_q != usr_pkg::RX_IDLE),
    .tx_tick(tx_tick),
    .rx_tick(rx_tick),
    .tx_count(tx_count),
    .rx_count(rx_count)
  );

  // ****************************************************************
  // Receive sequencer
  // ****************************************************************
  // Each rx_tick is half a bit, so bits are sampled on every second tick after the start check.
  assign sample = rx_tick & phase_q;
  assign done = sample & (state_q == usr_pkg::RX_STOP);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= usr_pkg::RX_IDLE;
      phase_q <= 1'b0;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      par_acc_q <= 1'b0;
      par_err_q <= 1'b0;
    end else if (!rx_active) begin
      state_q <= usr_pkg::RX_IDLE;
      phase_q <= 1'b0;
    end else begin
      if (rx_tick) begin
        phase_q <= ~phase_q;
      end
      case (state_q)
        usr_pkg::RX_IDLE: begin
          if (start_edge) begin
            state_q <= usr_pkg::RX_START;
            phase_q <= 1'b0;
          end
        end
        usr_pkg::RX_START: begin
          if (rx_tick) begin
            phase_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            par_acc_q <= 1'b0;
            par_err_q <= 1'b0;
            state_q <= norm ? usr_pkg::RX_IDLE : usr_pkg::RX_DATA;
          end
        end
        usr_pkg::RX_DATA: begin
          if (sample) begin
            shift_q[bit_cnt_q[2:0]] <= norm;
            par_acc_q <= par_acc_q ^ norm;
            bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
            if (bit_cnt_q == 4'(data_bits - 4'h1)) begin
              state_q <= parity_on ? usr_pkg::RX_PARITY : usr_pkg::RX_STOP;
            end
          end
        end
        usr_pkg::RX_PARITY: begin
          if (sample) begin
            par_err_q <= par_acc_q ^ norm ^ (parity_mode == usr_pkg::PAR_ODD);
            state_q <= usr_pkg::RX_STOP;
          end
        end
        usr_pkg::RX_STOP: begin
          if (sample) begin
            state_q <= usr_pkg::RX_IDLE;
          end
        end
        default: state_q <= usr_pkg::RX_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Receive buffer, status flags and interrupts
  // ****************************************************************
  // overrun cause
  assign err_set[usr_pkg::ST_OVERRUN] = done & buf_full_q;
  assign err_set[usr_pkg::ST_FRAMING] = done & ~norm;
  assign err_set[usr_pkg::ST_PARITY] = done & par_err_q;

  for (genvar i = 0; i < usr_pkg::ERR_FLAGS; i++) begin : g_flag
    assign err_clr[i] = (wr_clear & w_data_q[i]) | (rd_rx_buf & status_read_armed_q);

    // A new error in the same cycle as a clear is kept.
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        err_flags_q[i] <= 1'b0;
      end else if (err_set[i]) begin
        err_flags_q[i] <= 1'b1;
      end else if (err_clr[i]) begin
        err_flags_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_read_armed_q <= 1'b0;
    end else if (rd_status) begin
      status_read_armed_q <= 1'b1;
    end else if (rd_rx_buf) begin
      status_read_armed_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_buffer_reg_q <= 8'h00;
      buf_full_q <= 1'b0;
    end else if (done && !buf_full_q) begin
      rx_buffer_reg_q <= data_bits == usr_pkg::DATA_BITS_7 ? {1'b0, shift_q[6:0]} : shift_q;
      buf_full_q <= 1'b1;
    end else if (rd_rx_buf) begin
      buf_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_complete_irq_q <= 1'b0;
      rx_error_irq_q <= 1'b0;
    end else begin
      rx_complete_irq_q <= done & (~(|err_set) | err_route);
      rx_error_irq_q <= done & (|err_set) & ~err_route;
    end
  end

  assign rx_complete_irq = rx_complete_irq_q;
  assign rx_error_irq = rx_error_irq_q;

endmodule

`default_nettype wire

/* common/usr_pkg.sv */
`default_nettype none

package usr_pkg;

  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFF_MODE_A = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MODE_B = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DIVISOR = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RX_BUF = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_TX_BUF = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CLEAR = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_COUNTERS = 8'h1c;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int MA_ENABLE_BIT = 7;
  localparam int MA_TX_ENABLE_BIT = 6;
  localparam int MA_RX_ENABLE_BIT = 5;
  localparam int MA_ERR_ROUTE_BIT = 0;

  localparam int MB_LEVEL_BIT = 0;
  localparam int MB_PARITY_LSB = 1;
  localparam int MB_LEN7_BIT = 3;
  localparam int MB_STOP2_BIT = 4;

  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;

  localparam int ERR_FLAGS = 3;
  localparam int ST_OVERRUN = 0;
  localparam int ST_FRAMING = 1;
  localparam int ST_PARITY = 2;
  localparam int ST_BUF_FULL = 3;
  localparam int ST_BUSY = 4;

  localparam logic [7:0] MODE_A_RESET = 8'h00;
  localparam logic [7:0] MODE_B_RESET = 8'h00;
  localparam logic [7:0] DIVISOR_RESET = 8'hff;

  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_7 = 4'h7;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} usr_rx_state_e;

endpackage

`default_nettype wire

/* rtl/usr_baud_gen.sv */
`default_nettype none

module usr_baud_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic unit_enable,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic [7:0] divisor,
  input wire logic tx_clear,
  input wire logic rx_run,
  // Ticks and counts
  output logic tx_tick,
  output logic rx_tick,
  output logic [7:0] tx_count,
  output logic [7:0] rx_count
);

  logic [1:0] run;
  logic [1:0] clr;
  logic [1:0] tick;
  logic [7:0] cnt_q [2];

  assign run[0] = unit_enable & tx_enable;
  assign run[1] = unit_enable & rx_enable & rx_run;
  assign clr[0] = tx_clear;
  assign clr[1] = 1'b0;

  // ****************************************************************
  // Two independent counters
  // ****************************************************************
  // two independent counters
  for (genvar i = 0; i < 2; i++) begin : g_cnt
    assign tick[i] = run[i] & ~clr[i] & (cnt_q[i] == 8'(divisor - 8'h01));

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cnt_q[i] <= 8'h00;
      end else if (!run[i] || clr[i] || tick[i]) begin
        cnt_q[i] <= 8'h00;
      end else begin
        cnt_q[i] <= 8'(cnt_q[i] + 8'h01);
      end
    end
  end

  assign tx_tick = tick[0];
  assign rx_tick = tick[1];
  assign tx_count = cnt_q[0];
  assign rx_count = cnt_q[1];

endmodule

`default_nettype wire

/* testbench/usr_rx_asserts.sv */
`default_nettype none

module usr_rx_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [usr_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupts
  input wire logic rx_complete_irq,
  input wire logic rx_error_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  cplt_pulse_a: assert property (rx_complete_irq |=> !rx_complete_irq)
    else $error("complete interrupt longer than one cycle");
  err_pulse_a: assert property (rx_error_irq |=> !rx_error_irq)
    else $error("error interrupt longer than one cycle");
  irq_route_a: assert property (!(rx_complete_irq && rx_error_irq))
    else $error("both interrupt outputs raised together");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before acceptance");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before acceptance");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
endmodule

bind usr_rx_top usr_rx_asserts u_rx_chk (.clk(clk), .reset_n(reset_n), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .rx_complete_irq(rx_complete_irq), .rx_error_irq(rx_error_irq));

`default_nettype wire

/* testbench/usr_serial_tx_model.sv */
`default_nettype none

module usr_serial_tx_model (
  // Clock
  input wire logic clk,
  // Serial line
  output var logic line
);
  timeunit 1ns;
  timeprecision 100ps;

  // The line rests at the stop level between frames, as a pull-up holds it.
  initial line = 1'b1;

  task automatic put(input logic b, input int n);
    @(posedge clk);
    line <= b;
    repeat (n - 1) @(posedge clk);
  endtask

  task automatic send(input logic [7:0] d, input int nb, input logic [1:0] par, input logic bad,
                      input logic stp, input logic inv, input int bt);
    int i;
    logic p;
    p = ^(d & 8'((1 << nb) - 1)) ^ (par == usr_pkg::PAR_ODD) ^ bad;
    put(inv, bt);
    for (i = 0; i < nb; i++) put(d[i] ^ inv, bt);
    if (par == usr_pkg::PAR_EVEN || par == usr_pkg::PAR_ODD) put(p ^ inv, bt);
    put(stp ^ inv, bt);
    put(~inv, bt);
  endtask

  task automatic rest(input logic lvl);
    put(lvl, 8);
  endtask

  // A single-cycle dip that a two-sample filter must reject.
  task automatic glitch();
    put(1'b0, 1);
    put(1'b1, 1);
  endtask
endmodule

`default_nettype wire

/* testbench/usr_rx_top_tb.sv */
`default_nettype none

module usr_rx_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset_n, awv, wv, bv, br, arv, rv, rr, pin, ci, ei, awr, wr, arr;
  logic [3:0] ws;
  logic [1:0] bresp, rresp;
  logic [7:0] aw, ar;
  logic [31:0] wd, rd;
  int fail_count, n_tests, n_c, n_e;

  usr_rx_top DUT (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .serial_rx_pin(pin),
    .rx_complete_irq(ci), .rx_error_irq(ei));
  usr_serial_tx_model TX (.clk(clk), .line(pin));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (ci === 1'b1) n_c <= n_c + 1;
    if (ei === 1'b1) n_e <= n_e + 1;
  end

  // ****************************************************************
  // Bus tasks and comparisons
  // ****************************************************************
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic bad(input string m);
    fail_count++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) bad($sformatf("data %h expected %h", g, e));
  endtask
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    n_tests++;
    if (g !== e) bad($sformatf("response %h expected %h", g, e));
  endtask
  task automatic chk_num(input int g, input int e);
    n_tests++;
    if (g != e) bad($sformatf("pulse count %0d expected %0d", g, e));
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    // Ready follows the answer by one cycle, so the slave must hold its response.
    for (n = 0; n < 100 && !(bv && br); n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bv && !br) br <= 1'b1;
    end
    if (n == 100) bad("write timeout");
    if (n == 100) close_out();
    r = bresp;
    br <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    ar <= a;
    arv <= 1'b1;
    for (n = 0; n < 100 && !(rv && rr); n++) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv && !rr) rr <= 1'b1;
    end
    if (n == 100) bad("read timeout");
    if (n == 100) close_out();
    d = rd;
    r = rresp;
    rr <= 1'b0;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr_reg(a, d, r);
    chk_resp(r, usr_pkg::RESP_OKAY);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd_reg(a, d, r);
    chk_resp(r, usr_pkg::RESP_OKAY);
    chk_word(d, e);
  endtask
  // Bit time is 8 clocks with the divisor at 4.
  task automatic frame(input logic [7:0] d, input int nb, input logic [1:0] par, input logic pb, input logic stp,
                       input logic inv, input int ec, input int ee);
    int c0, n;
    c0 = n_c + n_e;
    TX.send(d, nb, par, pb, stp, inv, 8);
    for (n = 0; n < 100 && n_c + n_e == c0; n++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk_num(n_c + n_e - c0, ec + ee);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int i, j, c0;
    logic [31:0] d;
    logic [1:0] r;
    reset_n = 1'b0;
    {awv, wv, br, arv, rr} = 5'h00;
    ws = 4'hf;
    aw = 8'h00;
    ar = 8'h00;
    wd = 32'h0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rc(usr_pkg::OFF_MODE_A, 32'h00);
    rc(usr_pkg::OFF_MODE_B, 32'h00);
    rc(usr_pkg::OFF_DIVISOR, 32'hff);
    rc(usr_pkg::OFF_RX_BUF, 32'h00);
    rc(usr_pkg::OFF_STATUS, 32'h00);
    rd_reg(8'hfc, d, r);
    chk_resp(r, usr_pkg::RESP_SLVERR);
    chk_word(d, 32'h0);
    wr_reg(8'hfc, 32'h1, r);
    chk_resp(r, usr_pkg::RESP_SLVERR);
    $display("test reset and map done");
    w(usr_pkg::OFF_DIVISOR, 32'h04);
    w(usr_pkg::OFF_MODE_A, 32'h80);
    frame(8'h5a, 8, 2'h0, 1'b0, 1'b1, 1'b0, 0, 0);
    rc(usr_pkg::OFF_STATUS, 32'h00);
    rc(usr_pkg::OFF_COUNTERS, 32'h00);
    $display("test disabled done");
    w(usr_pkg::OFF_MODE_A, 32'ha0);
    frame(8'ha5, 8, 2'h0, 1'b0, 1'b1, 1'b0, 1, 0);
    chk_num(n_e, 0);
    rc(usr_pkg::OFF_STATUS, 32'h08);
    rc(usr_pkg::OFF_RX_BUF, 32'ha5);
    rc(usr_pkg::OFF_STATUS, 32'h00);
    c0 = n_c;
    TX.glitch();
    repeat (60) @(posedge clk);
    chk_num(n_c, c0);
    rc(usr_pkg::OFF_STATUS, 32'h00);
    $display("test plain frame done");
    for (i = 1; i < 3; i++) begin
      w(usr_pkg::OFF_MODE_B, 32'(i << 1));
      for (j = 0; j < 2; j++) begin
        c0 = n_e;
        frame(8'h96, 8, 2'(i), j[0], 1'b1, 1'b0, 1 - j, j);
        chk_num(n_e - c0, j);
        rc(usr_pkg::OFF_STATUS, 32'h08 | 32'(j << 2));
        rc(usr_pkg::OFF_RX_BUF, 32'h96);
        rc(usr_pkg::OFF_STATUS, 32'h00);
      end
    end
    $display("test parity done");
    w(usr_pkg::OFF_MODE_B, 32'h00);
    w(usr_pkg::OFF_MODE_A, 32'ha1);
    c0 = n_c;
    frame(8'h33, 8, 2'h0, 1'b0, 1'b0, 1'b0, 1, 0);
    chk_num(n_c - c0, 1);
    rc(usr_pkg::OFF_STATUS, 32'h0a);
    w(usr_pkg::OFF_CLEAR, 32'h02);
    rc(usr_pkg::OFF_STATUS, 32'h08);
    rc(usr_pkg::OFF_RX_BUF, 32'h33);
    $display("test framing done");
    w(usr_pkg::OFF_MODE_A, 32'ha0);
    frame(8'h11, 8, 2'h0, 1'b0, 1'b1, 1'b0, 1, 0);
    frame(8'h22, 8, 2'h0, 1'b0, 1'b1, 1'b0, 0, 1);
    rc(usr_pkg::OFF_STATUS, 32'h09);
    w(usr_pkg::OFF_CLEAR, 32'h01);
    rc(usr_pkg::OFF_STATUS, 32'h08);
    rc(usr_pkg::OFF_RX_BUF, 32'h11);
    $display("test overrun done");
    w(usr_pkg::OFF_MODE_A, 32'h80);
    TX.rest(1'b0);
    w(usr_pkg::OFF_MODE_B, 32'h01);
    w(usr_pkg::OFF_MODE_A, 32'ha0);
    frame(8'h3c, 8, 2'h0, 1'b0, 1'b1, 1'b1, 1, 0);
    rc(usr_pkg::OFF_RX_BUF, 32'h3c);
    w(usr_pkg::OFF_MODE_A, 32'h80);
    TX.rest(1'b1);
    w(usr_pkg::OFF_MODE_B, 32'h18);
    w(usr_pkg::OFF_MODE_A, 32'ha0);
    frame(8'hd5, 7, 2'h0, 1'b0, 1'b1, 1'b0, 1, 0);
    rc(usr_pkg::OFF_RX_BUF, 32'h55);
    rc(usr_pkg::OFF_STATUS, 32'h00);
    $display("test level and short frame done");
    close_out();
  end
endmodule

`default_nettype wire
